// file: src/dvc_cfg.svh
// Register map offsets, field positions, reset values and counts of the volume control bank
`ifndef DVC_CFG_SVH
`define DVC_CFG_SVH

// =====================================================
// Register offsets (7-bit control address)
`define DVC_ADDR_LEFT_LOW 7'h00
`define DVC_ADDR_LEFT_HIGH 7'h01
`define DVC_ADDR_RIGHT_LOW 7'h02
`define DVC_ADDR_RIGHT_HIGH 7'h03
`define DVC_ADDR_GAIN_MUTE 7'h04
`define DVC_ADDR_FORMAT 7'h05
`define DVC_ADDR_INTERP 7'h06
`define DVC_ADDR_MODE_A 7'h07
`define DVC_ADDR_MODE_B 7'h08
`define DVC_ADDR_SOFT_RESET 7'h09
`define DVC_ADDR_BITSTREAM 7'h20

// =====================================================
// Reset values
`define DVC_RST_ATTEN_PART 5'h00
`define DVC_RST_GAIN_MUTE 8'h00
`define DVC_RST_FORMAT 9'h00A
`define DVC_RST_INTERP 9'h000
`define DVC_RST_MODE_A 9'h000
`define DVC_RST_MODE_B 9'h002
`define DVC_RST_BITSTREAM 9'h000
`define DVC_RST_ATTEN 10'h000

// =====================================================
// Field positions
`define DVC_BIT_APPLY 5
`define DVC_BIT_RAMP 0
`define DVC_BIT_CLIP 1
`define DVC_BIT_GANG 2
`define DVC_BIT_SMUTE 3
`define DVC_BIT_IZD 4
`define DVC_BIT_ZROUTE_LO 5
`define DVC_BIT_ZROUTE_HI 6
`define DVC_BIT_SILENCE 7
`define DVC_BIT_ZFORCE 7
`define DVC_BIT_MODESEL_HI 1
`define DVC_BIT_MODESEL_LO 0

// =====================================================
// Codes and counts
`define DVC_MODESEL_PCM 2'h0
`define DVC_MODESEL_DIRECT 2'h1
`define DVC_MODESEL_PLUS 2'h2
`define DVC_ATTEN_MAX 10'h3FF
`define DVC_ATTEN_STEP 10'h001
`define DVC_ZERO_RUN 11'h400
`define DVC_ZERO_ONE 11'h001
`define DVC_FRAME_BITS 5'h10
`define DVC_BIT_ONE 5'h01

`endif

// file: src/dvc_pkg.sv
// Types shared by the volume control bank modules
package dvc_pkg;

	// =====================================================
	// One decoded control word from the serial port
	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [8:0] data;
	} dvc_wr_t;

	// Attenuation pair: index 0 left, index 1 right
	typedef logic [1:0][9:0] dvc_att_t;

	// Zero indicator routing codes
	typedef enum logic [1:0] {
		DVC_ZR_BOTH = 2'h0,
		DVC_ZR_LEFT = 2'h1,
		DVC_ZR_RIGHT = 2'h2,
		DVC_ZR_OFF = 2'h3
	} dvc_zroute_t;

	// Stored settings passed on to the datapath unchanged
	typedef struct packed {
		logic [8:0] format;
		logic [8:0] interp;
		logic [8:0] mode_a;
		logic [8:0] mode_b;
		logic [8:0] bitstream;
	} dvc_misc_cfg_t;

endpackage

// file: src/dvc_serial_rx.sv
// Three-wire serial control receiver: 16-bit frames of address and data
`timescale 1ns/10ps
`include "dvc_cfg.svh"

module dvc_serial_rx
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic ctl_sclk_i,
	input wire logic ctl_sdin_i,
	input wire logic ctl_latch_n_i,
	output dvc_pkg::dvc_wr_t wr_o
);

	typedef struct packed {
		logic [2:0] sclk;
		logic [2:0] latch_n;
		logic [1:0] sdin;
		logic [15:0] shift;
		logic [4:0] cnt;
		dvc_pkg::dvc_wr_t wr;
	} dvc_rx_state_t;

	dvc_rx_state_t st_r;
	dvc_rx_state_t st_nxt;
	logic sclk_rise;
	logic latch_rise;

	// =====================================================
	// Synchronisers, shifter and frame latch
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.sclk = {st_r.sclk[1:0], ctl_sclk_i};
		st_nxt.latch_n = {st_r.latch_n[1:0], ctl_latch_n_i};
		st_nxt.sdin = {st_r.sdin[0], ctl_sdin_i};
		st_nxt.wr.wr = 1'b0;
		sclk_rise = st_r.sclk[1] & ~st_r.sclk[2];
		latch_rise = st_r.latch_n[1] & ~st_r.latch_n[2];
		if (st_r.latch_n[1] && !latch_rise)
			st_nxt.cnt = 5'h00;
		else if (sclk_rise && !st_r.latch_n[1] && st_r.cnt != `DVC_FRAME_BITS)
		begin
			st_nxt.shift = {st_r.shift[14:0], st_r.sdin[1]};
			st_nxt.cnt = st_r.cnt + `DVC_BIT_ONE;
		end
		// Frames shorter than 16 bits are dropped; bits after the sixteenth are ignored
		if (latch_rise && st_r.cnt == `DVC_FRAME_BITS)
		begin
			st_nxt.wr.wr = 1'b1;
			st_nxt.wr.addr = st_r.shift[15:9];
			st_nxt.wr.data = st_r.shift[8:0];
		end
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			st_r <= '{sclk: 3'h0, latch_n: 3'h7, sdin: 2'h0, shift: 16'h0000,
				cnt: 5'h00, wr: '0};
		else if (ce_i)
			st_r <= st_nxt;
	end

	assign wr_o = st_r.wr;

endmodule // dvc_serial_rx

// file: src/dvc_zero_detect.sv
// Run detector for consecutive zero input samples on one channel
`timescale 1ns/10ps
`include "dvc_cfg.svh"

module dvc_zero_detect
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic zero_i,
	output logic zero_o
);

	typedef struct packed {
		logic [10:0] cnt;
		logic zero;
	} dvc_zd_state_t;

	dvc_zd_state_t st_r;
	dvc_zd_state_t st_nxt;

	// =====================================================
	// Saturating zero-run counter
	always_comb
	begin
		st_nxt = st_r;
		if (!en_i)
			st_nxt.cnt = 11'h000;
		else if (tick_i)
		begin
			if (!zero_i)
				st_nxt.cnt = 11'h000;
			else if (st_r.cnt != `DVC_ZERO_RUN)
				st_nxt.cnt = st_r.cnt + `DVC_ZERO_ONE;
		end
		st_nxt.zero = (st_nxt.cnt == `DVC_ZERO_RUN);
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			st_r <= '0;
		else if (ce_i)
			st_r <= st_nxt;
	end

	assign zero_o = st_r.zero;

	// =====================================================
	// Checks
	a_zero_needs_run: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(zero_o) |-> $past(st_r.cnt) == 11'h3FF && $past(en_i))
		else $error("zero flag rose without a full run");
	a_zero_needs_en: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(!en_i && ce_i) |=> !zero_o)
		else $error("zero flag set while detection disabled");

endmodule // dvc_zero_detect

// file: src/dvc_regs.sv
// Volume control register bank: staged attenuation, ramping, mute and zero flag routing
`timescale 1ns/10ps
`include "dvc_cfg.svh"

// Overview of operation
// - Left low attenuation part, eighth-dB steps
// - Left high attenuation part, four-dB steps
// - Right low attenuation part, eighth-dB steps
// - Right high attenuation part, four-dB steps
// - Apply flag clear: store only
// - Apply flag set: apply stored parts, left pair to both when ganged
// - Ramp bit: gradual change, else step
// - Anti-clip bit cuts gain two dB
// - Gang bit: right uses left value
// - Soft mute bit mutes both channels
// - Zero detect enable, 1024 sample run
// - Route field selects zero indicator source
// - Analogue mute in one-bit-stream mode
module dvc_regs
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic ctl_sclk_i,
	input wire logic ctl_sdin_i,
	input wire logic ctl_latch_n_i,
	input wire logic sample_tick_i,
	input wire logic left_zero_sample_i,
	input wire logic right_zero_sample_i,
	output logic [9:0] left_atten_value_o,
	output logic [9:0] right_atten_value_o,
	output logic ramp_busy_o,
	output logic soft_mute_o,
	output logic anti_clip_cut_o,
	output logic zero_indicator_out_o,
	output logic output_stage_silence_o,
	output dvc_pkg::dvc_misc_cfg_t misc_cfg_o
);

	typedef struct packed {
		logic [4:0] left_low_part;
		logic [4:0] left_high_part;
		logic [4:0] right_low_part;
		logic [4:0] right_high_part;
		logic [7:0] gain_mute;
		dvc_pkg::dvc_misc_cfg_t misc;
		dvc_pkg::dvc_att_t tgt;
		dvc_pkg::dvc_att_t cur;
		logic busy;
		logic smute;
		logic clip;
		logic zero_indicator_out;
		logic silence;
	} dvc_regs_state_t;

	localparam dvc_regs_state_t DVC_RST_STATE = '{
		left_low_part: `DVC_RST_ATTEN_PART,
		left_high_part: `DVC_RST_ATTEN_PART,
		right_low_part: `DVC_RST_ATTEN_PART,
		right_high_part: `DVC_RST_ATTEN_PART,
		gain_mute: `DVC_RST_GAIN_MUTE,
		misc: '{format: `DVC_RST_FORMAT, interp: `DVC_RST_INTERP,
			mode_a: `DVC_RST_MODE_A, mode_b: `DVC_RST_MODE_B,
			bitstream: `DVC_RST_BITSTREAM},
		tgt: {`DVC_RST_ATTEN, `DVC_RST_ATTEN},
		cur: {`DVC_RST_ATTEN, `DVC_RST_ATTEN},
		busy: 1'b0,
		smute: 1'b0,
		clip: 1'b0,
		zero_indicator_out: 1'b0,
		silence: 1'b0
	};

	dvc_regs_state_t st_r;
	dvc_regs_state_t st_nxt;
	dvc_pkg::dvc_wr_t wr;
	logic [1:0] chan_zero;
	logic [1:0] chan_zero_sample;
	logic apply;
	logic [9:0] eff_tgt;
	dvc_pkg::dvc_zroute_t zroute;

	// =====================================================
	// Helpers
	// One attenuation step toward the goal
	function automatic logic [9:0] step_toward(input logic [9:0] cur, input logic [9:0] goal);
		if (cur < goal)
			step_toward = cur + `DVC_ATTEN_STEP;
		else if (cur > goal)
			step_toward = cur - `DVC_ATTEN_STEP;
		else
			step_toward = cur;
	endfunction

	// True when the mode field selects a one-bit-stream path
	function automatic logic is_one_bit_stream(input logic [8:0] mode_a);
		is_one_bit_stream =
			(mode_a[`DVC_BIT_MODESEL_HI:`DVC_BIT_MODESEL_LO] == `DVC_MODESEL_DIRECT) ||
			(mode_a[`DVC_BIT_MODESEL_HI:`DVC_BIT_MODESEL_LO] == `DVC_MODESEL_PLUS);
	endfunction

	// True for a write to one of the four attenuation parts
	function automatic logic is_atten_addr(input logic [6:0] addr);
		is_atten_addr = (addr == `DVC_ADDR_LEFT_LOW) || (addr == `DVC_ADDR_LEFT_HIGH) ||
			(addr == `DVC_ADDR_RIGHT_LOW) || (addr == `DVC_ADDR_RIGHT_HIGH);
	endfunction

	// =====================================================
	// Serial control port
	dvc_serial_rx u_rx
	(
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.ctl_sclk_i(ctl_sclk_i),
		.ctl_sdin_i(ctl_sdin_i),
		.ctl_latch_n_i(ctl_latch_n_i),
		.wr_o(wr)
	);

	// =====================================================
	// Per-channel zero run detectors
	assign chan_zero_sample = {right_zero_sample_i, left_zero_sample_i};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_zero
			dvc_zero_detect u_zd
			(
				.mclk_i(mclk_i),
				.rst_n_i(rst_n_i),
				.ce_i(ce_i),
				.en_i(st_r.gain_mute[`DVC_BIT_IZD]),
				.tick_i(sample_tick_i),
				.zero_i(chan_zero_sample[gi]),
				.zero_o(chan_zero[gi])
			);
		end
	endgenerate

	// =====================================================
	// Next state
	always_comb
	begin
		st_nxt = st_r;
		eff_tgt = `DVC_RST_ATTEN;
		zroute = dvc_pkg::dvc_zroute_t'(st_r.gain_mute[`DVC_BIT_ZROUTE_HI:`DVC_BIT_ZROUTE_LO]);
		apply = wr.wr && is_atten_addr(wr.addr) && wr.data[`DVC_BIT_APPLY];
		// Register writes; parts are stored whatever the apply flag says
		if (wr.wr)
		begin
			unique case (wr.addr)
				`DVC_ADDR_LEFT_LOW: st_nxt.left_low_part = wr.data[4:0];
				`DVC_ADDR_LEFT_HIGH: st_nxt.left_high_part = wr.data[4:0];
				`DVC_ADDR_RIGHT_LOW: st_nxt.right_low_part = wr.data[4:0];
				`DVC_ADDR_RIGHT_HIGH: st_nxt.right_high_part = wr.data[4:0];
				`DVC_ADDR_GAIN_MUTE: st_nxt.gain_mute = wr.data[7:0];
				`DVC_ADDR_FORMAT: st_nxt.misc.format = wr.data;
				`DVC_ADDR_INTERP: st_nxt.misc.interp = wr.data;
				`DVC_ADDR_MODE_A: st_nxt.misc.mode_a = wr.data;
				`DVC_ADDR_MODE_B: st_nxt.misc.mode_b = wr.data;
				`DVC_ADDR_BITSTREAM: st_nxt.misc.bitstream = wr.data;
				default: ;
			endcase
		end
		// Apply: the stored parts become the target, the left parts for both channels when ganged
		if (apply)
		begin
			st_nxt.tgt[0] = {st_nxt.left_high_part, st_nxt.left_low_part};
			if (st_r.gain_mute[`DVC_BIT_GANG])
				st_nxt.tgt[1] = st_nxt.tgt[0];
			else
				st_nxt.tgt[1] = {st_nxt.right_high_part, st_nxt.right_low_part};
		end
		// Active attenuation follows the target, ramped or stepped
		for (int i = 0; i < 2; i++)
		begin
			eff_tgt = st_r.gain_mute[`DVC_BIT_SMUTE] ? `DVC_ATTEN_MAX : st_r.tgt[i];
			if (st_r.gain_mute[`DVC_BIT_RAMP] || st_r.gain_mute[`DVC_BIT_SMUTE])
			begin
				if (sample_tick_i)
					st_nxt.cur[i] = step_toward(st_r.cur[i], eff_tgt);
			end
			else
				st_nxt.cur[i] = eff_tgt;
		end
		st_nxt.busy = (st_nxt.cur[0] != st_nxt.tgt[0]) || (st_nxt.cur[1] != st_nxt.tgt[1]);
		st_nxt.smute = st_r.gain_mute[`DVC_BIT_SMUTE];
		st_nxt.clip = st_r.gain_mute[`DVC_BIT_CLIP];
		st_nxt.silence = st_r.gain_mute[`DVC_BIT_SILENCE] && is_one_bit_stream(st_r.misc.mode_a);
		// Zero indicator routing, with the force-high override
		unique case (zroute)
			dvc_pkg::DVC_ZR_BOTH: st_nxt.zero_indicator_out = chan_zero[0] & chan_zero[1];
			dvc_pkg::DVC_ZR_LEFT: st_nxt.zero_indicator_out = chan_zero[0];
			dvc_pkg::DVC_ZR_RIGHT: st_nxt.zero_indicator_out = chan_zero[1];
			dvc_pkg::DVC_ZR_OFF: st_nxt.zero_indicator_out = 1'b0;
		endcase
		if (st_r.misc.interp[`DVC_BIT_ZFORCE])
			st_nxt.zero_indicator_out = 1'b1;
		// Soft reset write restores every default
		if (wr.wr && wr.addr == `DVC_ADDR_SOFT_RESET)
			st_nxt = DVC_RST_STATE;
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			st_r <= DVC_RST_STATE;
		else if (ce_i)
			st_r <= st_nxt;
	end

	// =====================================================
	// Outputs, all from the state register
	assign left_atten_value_o = st_r.cur[0];
	assign right_atten_value_o = st_r.cur[1];
	assign ramp_busy_o = st_r.busy;
	assign soft_mute_o = st_r.smute;
	assign anti_clip_cut_o = st_r.clip;
	assign zero_indicator_out_o = st_r.zero_indicator_out;
	assign output_stage_silence_o = st_r.silence;
	assign misc_cfg_o = st_r.misc;

	// =====================================================
	// Checks
	sequence s_write(logic [6:0] a);
		ce_i && wr.wr && wr.addr == a;
	endsequence

	sequence s_apply_write;
		ce_i && apply && wr.addr != `DVC_ADDR_SOFT_RESET;
	endsequence

	a_left_low_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_write(`DVC_ADDR_LEFT_LOW) |=> st_r.left_low_part == $past(wr.data[4:0]))
		else $error("left low part not stored");
	a_left_high_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_write(`DVC_ADDR_LEFT_HIGH) |=> st_r.left_high_part == $past(wr.data[4:0]))
		else $error("left high part not stored");
	a_right_low_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_write(`DVC_ADDR_RIGHT_LOW) |=> st_r.right_low_part == $past(wr.data[4:0]))
		else $error("right low part not stored");
	a_right_high_store: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_write(`DVC_ADDR_RIGHT_HIGH) |=> st_r.right_high_part == $past(wr.data[4:0]))
		else $error("right high part not stored");
	a_store_no_apply: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && wr.wr && is_atten_addr(wr.addr) && !wr.data[`DVC_BIT_APPLY]) |=> $stable(st_r.tgt))
		else $error("target changed without apply flag");
	a_apply_left: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_apply_write |=> st_r.tgt[0] == {st_r.left_high_part, st_r.left_low_part})
		else $error("apply did not load left target");
	a_apply_right: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(s_apply_write and !st_r.gain_mute[`DVC_BIT_GANG])
		|=> st_r.tgt[1] == {st_r.right_high_part, st_r.right_low_part})
		else $error("apply did not load right target");
	a_step_direct: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && !st_r.gain_mute[`DVC_BIT_RAMP] && !st_r.gain_mute[`DVC_BIT_SMUTE]
		&& !(wr.wr && wr.addr == `DVC_ADDR_SOFT_RESET)) |=> st_r.cur == $past(st_r.tgt))
		else $error("step mode did not jump to target");
	a_busy_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		ramp_busy_o == (st_r.cur != st_r.tgt))
		else $error("busy flag does not match ramp progress");
	a_ramp_single_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && st_r.gain_mute[`DVC_BIT_RAMP] && !st_r.gain_mute[`DVC_BIT_SMUTE] && !sample_tick_i
		&& !(wr.wr && wr.addr == `DVC_ADDR_SOFT_RESET)) |=> $stable(st_r.cur))
		else $error("ramp moved without a sample tick");
	a_clip_follows: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(s_write(`DVC_ADDR_GAIN_MUTE) ##1 ce_i) |=> anti_clip_cut_o == $past(wr.data[`DVC_BIT_CLIP], 2))
		else $error("anti-clip output does not follow its bit");
	a_gang_right: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(s_apply_write and st_r.gain_mute[`DVC_BIT_GANG]) |=> st_r.tgt[1] == st_r.tgt[0])
		else $error("ganged right target differs from left");
	a_mute_rises: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && st_r.gain_mute[`DVC_BIT_SMUTE] && !wr.wr) |=> st_r.cur[0] >= $past(st_r.cur[0]))
		else $error("attenuation fell during soft mute");
	a_mute_mirror: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && !(wr.wr && wr.addr == `DVC_ADDR_SOFT_RESET))
		|=> soft_mute_o == $past(st_r.gain_mute[`DVC_BIT_SMUTE]))
		else $error("soft mute output does not follow its bit");
	a_zero_left: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && zroute == dvc_pkg::DVC_ZR_LEFT && !st_r.misc.interp[`DVC_BIT_ZFORCE]
		&& !wr.wr) |=> zero_indicator_out_o == $past(chan_zero[0]))
		else $error("zero indicator does not follow left channel");
	a_zero_force: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && st_r.misc.interp[`DVC_BIT_ZFORCE] && !wr.wr) |=> zero_indicator_out_o)
		else $error("zero indicator not forced high");
	a_zero_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && zroute == dvc_pkg::DVC_ZR_OFF && !st_r.misc.interp[`DVC_BIT_ZFORCE]
		&& !wr.wr) |=> !zero_indicator_out_o)
		else $error("zero indicator set while routed off");
	a_silence_mode: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && !is_one_bit_stream(st_r.misc.mode_a)) |=> !output_stage_silence_o)
		else $error("analogue mute outside one-bit-stream mode");
	a_silence_on: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && st_r.gain_mute[`DVC_BIT_SILENCE] && is_one_bit_stream(st_r.misc.mode_a)
		&& !wr.wr) |=> output_stage_silence_o)
		else $error("analogue mute missing in one-bit-stream mode");
	a_soft_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_write(`DVC_ADDR_SOFT_RESET) |=> (st_r.gain_mute == `DVC_RST_GAIN_MUTE
		&& st_r.tgt == '0 && st_r.misc.format == `DVC_RST_FORMAT))
		else $error("soft reset did not restore defaults");

endmodule // dvc_regs

// file: dv/dvc_host_model.sv
// Host controller model that sends control words over the three-wire port
`timescale 1ns/10ps

module dvc_host_model
(
	input wire logic mclk_i,
	output logic sclk_o,
	output logic sdin_o,
	output logic latch_n_o
);
	// =====================================================
	// Idle state: serial clock still, select released
	initial
	begin
		sclk_o = 1'b0;
		sdin_o = 1'b0;
		latch_n_o = 1'b1;
	end

	// Hold each pin level for four master clocks, above the synchroniser need
	task automatic hold();
		repeat (4) @(negedge mclk_i);
	endtask

	// One frame: seven address bits then nine data bits, top bit first
	task automatic send(input logic [6:0] addr, input logic [8:0] data);
		logic [15:0] word;
		word = {addr, data};
		@(negedge mclk_i);
		latch_n_o = 1'b0;
		hold();
		for (int k = 15; k >= 0; k--)
		begin
			sdin_o = word[k];
			hold();
			sclk_o = 1'b1;
			hold();
			sclk_o = 1'b0;
		end
		hold();
		latch_n_o = 1'b1;
		hold();
		sdin_o = ~sdin_o; // Data line no longer valid, show a changed level
	endtask
endmodule // dvc_host_model

// file: dv/dvc_regs_tb.sv
// Self-checking bench for the volume control register bank
`timescale 1ns/10ps
`include "dvc_cfg.svh"

module dvc_regs_tb;
	// =====================================================
	// Clock, stimulus and observed signals
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic tick = 1'b0;
	logic lzero = 1'b0;
	logic rzero = 1'b0;
	logic sclk;
	logic sdin;
	logic latch_n;
	logic [9:0] latt;
	logic [9:0] ratt;
	logic busy;
	logic smute;
	logic clip;
	logic zero_indicator_out;
	logic silence;
	dvc_pkg::dvc_misc_cfg_t misc;
	int err_total = 0;
	int checked = 0;
	localparam logic [44:0] MISC_RST = {9'h00A, 9'h000, 9'h000, 9'h002, 9'h000};

	// Master clock, 10 ns period
	always #5 mclk = ~mclk;

	// =====================================================
	// Host model and device
	dvc_host_model host (.mclk_i(mclk), .sclk_o(sclk), .sdin_o(sdin), .latch_n_o(latch_n));

	dvc_regs dut
	(
		.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1),
		.ctl_sclk_i(sclk), .ctl_sdin_i(sdin), .ctl_latch_n_i(latch_n),
		.sample_tick_i(tick), .left_zero_sample_i(lzero), .right_zero_sample_i(rzero),
		.left_atten_value_o(latt), .right_atten_value_o(ratt), .ramp_busy_o(busy),
		.soft_mute_o(smute), .anti_clip_cut_o(clip), .zero_indicator_out_o(zero_indicator_out),
		.output_stage_silence_o(silence), .misc_cfg_o(misc)
	);

	// =====================================================
	// Comparison and reporting
	task automatic report(input string what, input logic [44:0] exp, input logic [44:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_att(input string what, input logic [9:0] exp, input logic [9:0] got);
		report(what, {35'h0, exp}, {35'h0, got});
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
		report(what, {44'h0, exp}, {44'h0, got});
	endtask

	task automatic chk_misc(input string what, input logic [44:0] exp, input logic [44:0] got);
		report(what, exp, got);
	endtask

	task automatic done(input string what);
		$display("Test %s finished, mismatches so far %0d", what, err_total);
	endtask

	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// =====================================================
	// Bus and sample helpers
	task automatic wr(input logic [6:0] addr, input logic [8:0] data);
		host.send(addr, data);
		repeat (8) @(negedge mclk);
	endtask

	// Sample pulses every second clock with given zero indications
	task automatic ticks(input int n, input logic lz, input logic rz);
		repeat (n)
		begin
			@(negedge mclk);
			tick = 1'b1;
			lzero = lz;
			rzero = rz;
			@(negedge mclk);
			tick = 1'b0;
		end
		repeat (4) @(negedge mclk);
	endtask

	// =====================================================
	// Test sequence
	initial
	begin
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk_att("left reset", 10'h000, latt);
		chk_att("right reset", 10'h000, ratt);
		chk_flag("clip reset", 1'b0, clip);
		chk_misc("misc reset", MISC_RST, misc);
		done("reset");
		wr(`DVC_ADDR_LEFT_LOW, 9'h015);
		wr(`DVC_ADDR_LEFT_HIGH, 9'h00A);
		wr(`DVC_ADDR_RIGHT_LOW, 9'h003);
		chk_att("left held", 10'h000, latt);
		wr(`DVC_ADDR_RIGHT_HIGH, 9'h031);
		chk_att("left applied", 10'h155, latt);
		chk_att("right applied", 10'h223, ratt);
		done("staged load");
		wr(`DVC_ADDR_GAIN_MUTE, 9'h006);
		chk_flag("clip on", 1'b1, clip);
		wr(`DVC_ADDR_LEFT_LOW, 9'h035);
		chk_att("right ganged", 10'h155, ratt);
		done("gang and clip");
		wr(`DVC_ADDR_GAIN_MUTE, 9'h001);
		chk_flag("clip off", 1'b0, clip);
		wr(`DVC_ADDR_LEFT_LOW, 9'h038);
		chk_flag("ramp busy", 1'b1, busy);
		ticks(3, 1'b0, 1'b0);
		chk_att("left ramp", 10'h158, latt);
		chk_att("right ramp", 10'h158, ratt);
		ticks(210, 1'b0, 1'b0);
		chk_att("right ramp end", 10'h223, ratt);
		chk_flag("ramp idle", 1'b0, busy);
		done("ramp");
		wr(`DVC_ADDR_GAIN_MUTE, 9'h009);
		chk_flag("soft mute on", 1'b1, smute);
		ticks(1100, 1'b0, 1'b0);
		chk_att("left muted", 10'h3FF, latt);
		chk_att("right muted", 10'h3FF, ratt);
		wr(`DVC_ADDR_GAIN_MUTE, 9'h001);
		chk_flag("soft mute off", 1'b0, smute);
		ticks(1100, 1'b0, 1'b0);
		chk_att("left restored", 10'h158, latt);
		chk_att("right restored", 10'h223, ratt);
		done("soft mute");
		wr(`DVC_ADDR_GAIN_MUTE, 9'h010);
		ticks(1023, 1'b1, 1'b1);
		chk_flag("zero early", 1'b0, zero_indicator_out);
		ticks(1, 1'b1, 1'b1);
		chk_flag("zero run", 1'b1, zero_indicator_out);
		ticks(1, 1'b1, 1'b0);
		for (int c = 0; c < 4; c++)
		begin
			wr(`DVC_ADDR_GAIN_MUTE, {2'h0, c[1:0], 5'h10});
			chk_flag("zero route", c == 1, zero_indicator_out);
		end
		wr(`DVC_ADDR_GAIN_MUTE, 9'h020);
		chk_flag("zero disabled", 1'b0, zero_indicator_out);
		done("zero detect");
		wr(`DVC_ADDR_MODE_A, 9'h001);
		wr(`DVC_ADDR_GAIN_MUTE, 9'h080);
		chk_flag("silence direct", 1'b1, silence);
		wr(`DVC_ADDR_MODE_A, 9'h000);
		chk_flag("silence pcm", 1'b0, silence);
		wr(`DVC_ADDR_MODE_A, 9'h002);
		chk_flag("silence plus", 1'b1, silence);
		done("analogue mute");
		wr(`DVC_ADDR_FORMAT, 9'h0C3);
		wr(`DVC_ADDR_INTERP, 9'h080);
		chk_flag("zero forced", 1'b1, zero_indicator_out);
		wr(`DVC_ADDR_BITSTREAM, 9'h003);
		wr(7'h0A, 9'h1FF);
		chk_misc("misc stored", {9'h0C3, 9'h080, 9'h002, 9'h002, 9'h003}, misc);
		wr(`DVC_ADDR_SOFT_RESET, 9'h000);
		chk_misc("misc soft reset", MISC_RST, misc);
		chk_att("left soft reset", 10'h000, latt);
		chk_att("right soft reset", 10'h000, ratt);
		chk_flag("silence soft reset", 1'b0, silence);
		chk_flag("zero soft reset", 1'b0, zero_indicator_out);
		done("soft reset");
		summarize();
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (40000) @(posedge mclk);
		err_total++;
		summarize();
	end
endmodule // dvc_regs_tb
